// [rtl/arc_defs.svh]
// Named constants for the reference select and result coding block.
`ifndef ARC_DEFS_SVH
`define ARC_DEFS_SVH
`define ARC_SEL_W        3
`define ARC_SEL_RST      3'h0
`define ARC_SEL_AUTO_SD  3'h4
`define ARC_SEL_TOP      2
`define ARC_SEL_MID      1
`define ARC_SEL_LOW      0
`define ARC_CH_W         4
`define ARC_CH_RST       4'h0
`define ARC_CH_CAP_SMALL 4'h2
`define ARC_CH_CAP_LARGE 4'ha
`define ARC_CH_MAX_SMALL 4'h3
`define ARC_CH_MAX_LARGE 4'hb
`define ARC_RES_W        12
`define ARC_RES_MSB      11
`endif

// [rtl/arc_pkg.sv]
// Types shared by the reference select and result coding block.
package arc_pkg;
  typedef enum logic [1:0] {
    ARC_REF_SUPPLY,
    ARC_REF_EXTERNAL,
    ARC_REF_INTERNAL
  } arc_ref_src_t;

  typedef enum logic [1:0] {
    ARC_PIN_ANALOG,
    ARC_PIN_REF_IN,
    ARC_PIN_REF_OUT
  } arc_pin_mode_t;

  typedef enum logic [1:0] {
    ARC_PWR_OFF,
    ARC_PWR_ON
  } arc_pwr_state_t;
endpackage

// [rtl/arc_result_coder.sv]
// Output coder for one conversion result, straight or two's complement.
`timescale 1ns/1ns
`include "arc_defs.svh"
module arc_result_coder #(
  parameter int RES_W = `ARC_RES_W
) (
  input  wire logic             core_clk_i,
  input  wire logic             nrst_i,
  input  wire logic             bipolar_i,
  input  wire logic             valid_i,
  input  wire logic [RES_W-1:0] offset_code_i,
  output logic                  valid_o,
  output logic      [RES_W-1:0] result_o
);
  // Bipolar results come in offset form; flipping the sign bit gives
  // two's complement without an adder.
  logic [RES_W-1:0] next_result;
  assign next_result = bipolar_i ? // [RL6]
    {~offset_code_i[RES_W-1], offset_code_i[RES_W-2:0]} : offset_code_i;

  // Result register, loaded only when a new conversion arrives.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      result_o <= '0;
      valid_o  <= 1'b0;
    end else begin
      valid_o <= valid_i;
      if (valid_i) begin
        result_o <= next_result;
      end
    end
  end

  a_coding_exact: assert property ( // [RL6]
    @(posedge core_clk_i) disable iff (!nrst_i)
    valid_i |=> result_o == (($past(bipolar_i)) ?
      ($past(offset_code_i) ^ {1'b1, {(RES_W-1){1'b0}}}) :
      $past(offset_code_i)))
    else $error("Result coding does not match the polarity mode.");
endmodule

// [rtl/arc_ref_ctrl.sv]
// Reference select decode, channel limiter and result coding control.
//
// Notes on behaviour
// RL1: Reference is supply, external or internal according to the select bits.
// RL2: Middle bit makes shared pin a reference; both upper bits drive it.
// RL3: Lowest select bit with internal reference keeps reference powered.
// RL4: Differential pairs see a reference shared pin as ground.
// RL5: Single-ended scans skip the shared pin, capping at channel two or ten.
// RL6: Results are straight binary unipolar, two's complement bipolar.
// RL7: Reset: single-ended, unipolar, channel zero, internal clock, supply.
// RL8: Automatic shutdown code powers analog down when idle, up on address.
`timescale 1ns/1ns
`include "arc_defs.svh"
module arc_ref_ctrl #(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter int RES_W         = `ARC_RES_W
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   nrst_i,
  input  wire logic                   setup_wr_i,
  input  wire logic [`ARC_SEL_W-1:0]  setup_sel_i,
  input  wire logic                   setup_ext_clk_i,
  input  wire logic                   setup_bipolar_i,
  input  wire logic                   cfg_wr_i,
  input  wire logic                   cfg_single_ended_i,
  input  wire logic [`ARC_CH_W-1:0]   cfg_chan_i,
  input  wire logic                   addr_match_i,
  input  wire logic                   conv_busy_i,
  input  wire logic                   conv_done_i,
  input  wire logic [RES_W-1:0]       conv_code_i,
  input  wire logic [`ARC_CH_W-1:0]   conv_chan_i,
  input  wire logic                   conv_diff_i,
  output arc_pkg::arc_ref_src_t       ref_src_o,
  output arc_pkg::arc_pin_mode_t      pin_mode_o,
  output logic                        pin_function_bit_o,
  output logic                        int_ref_hold_o,
  output logic                        analog_pwr_o,
  output logic                        ext_clk_o,
  output logic                        bipolar_o,
  output logic                        single_ended_o,
  output logic [`ARC_CH_W-1:0]        chan_sel_o,
  output logic [`ARC_CH_W-1:0]        scan_top_o,
  output logic                        shared_pin_as_gnd_o,
  output logic                        result_valid_o,
  output logic [RES_W-1:0]            result_o
);
  // **********************************************************************
  // Setup and configuration state
  // **********************************************************************
  logic [`ARC_SEL_W-1:0] sel;
  logic                  ext_clk;
  logic                  bipolar;
  logic                  single_ended;
  logic [`ARC_CH_W-1:0]  chan;
  arc_pkg::arc_pwr_state_t pwr;

  // Setup and config fields; reset gives the power-on defaults.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      sel          <= `ARC_SEL_RST;    // [RL7]
      ext_clk      <= 1'b0;            // [RL7]
      bipolar      <= 1'b0;            // [RL7]
      single_ended <= 1'b1;            // [RL7]
      chan         <= `ARC_CH_RST;     // [RL7]
    end else begin
      if (setup_wr_i) begin
        sel     <= setup_sel_i;
        ext_clk <= setup_ext_clk_i;
        bipolar <= setup_bipolar_i;
      end
      if (cfg_wr_i) begin
        single_ended <= cfg_single_ended_i;
        chan         <= cfg_chan_i;
      end
    end
  end

  // **********************************************************************
  // Reference decode
  // **********************************************************************
  wire sel_top = sel[`ARC_SEL_TOP];
  wire sel_mid = sel[`ARC_SEL_MID];
  wire sel_low = sel[`ARC_SEL_LOW];
  wire auto_sd = (sel == `ARC_SEL_AUTO_SD);

  // Source follows the top bit first, then the middle bit.
  assign ref_src_o = sel_top ? arc_pkg::ARC_REF_INTERNAL :
                     sel_mid ? arc_pkg::ARC_REF_EXTERNAL :
                               arc_pkg::ARC_REF_SUPPLY;      // [RL1]

  // Pin is analog unless the middle bit is set.
  assign pin_function_bit_o = sel_mid;                      // [RL2]
  assign pin_mode_o = !sel_mid ? arc_pkg::ARC_PIN_ANALOG :
                      sel_top  ? arc_pkg::ARC_PIN_REF_OUT :
                                 arc_pkg::ARC_PIN_REF_IN;    // [RL2]

  // Held on only while the stored code says so; writing a code without both
  // the top and lowest bits drops it in the cycle after the write.
  assign int_ref_hold_o = sel_top & sel_low;                 // [RL3]

  // **********************************************************************
  // Automatic shutdown
  // **********************************************************************
  // Waking on the address byte keeps the idle current low; the internal
  // reference still needs its own settle time, which is not modelled here.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      pwr <= arc_pkg::ARC_PWR_ON;
    end else begin
      unique case (pwr)
        arc_pkg::ARC_PWR_ON: begin
          if (auto_sd && !conv_busy_i && !addr_match_i) begin
            pwr <= arc_pkg::ARC_PWR_OFF;                     // [RL8]
          end
        end
        arc_pkg::ARC_PWR_OFF: begin
          if (!auto_sd || addr_match_i) begin
            pwr <= arc_pkg::ARC_PWR_ON;                      // [RL8]
          end
        end
      endcase
    end
  end
  assign analog_pwr_o = (pwr == arc_pkg::ARC_PWR_ON);

  // **********************************************************************
  // Channel limiter
  // **********************************************************************
  function automatic logic [`ARC_CH_W-1:0] cap_chan(
    input logic [`ARC_CH_W-1:0] c,
    input logic [`ARC_CH_W-1:0] lim
  );
    cap_chan = (c > lim) ? lim : c;
  endfunction

  wire [`ARC_CH_W-1:0] top_full = LARGE_VARIANT ? `ARC_CH_MAX_LARGE :
                                                  `ARC_CH_MAX_SMALL;
  wire [`ARC_CH_W-1:0] top_ref  = LARGE_VARIANT ? `ARC_CH_CAP_LARGE :
                                                  `ARC_CH_CAP_SMALL;
  // The shared pin is the last channel, so skipping it lowers the cap.
  assign scan_top_o = (sel_mid && single_ended) ?
                      cap_chan(chan, top_ref) :
                      cap_chan(chan, top_full);              // [RL5]

  // A differential pair naming the shared pin sees ground on that side.
  assign shared_pin_as_gnd_o = sel_mid && conv_diff_i &&
                               (conv_chan_i == top_full);    // [RL4]

  assign ext_clk_o      = ext_clk;
  assign bipolar_o      = bipolar;
  assign single_ended_o = single_ended;
  assign chan_sel_o     = chan;

  // **********************************************************************
  // Result coding
  // **********************************************************************
  arc_result_coder #(
    .RES_W (RES_W)
  ) u_coder (
    .core_clk_i    (core_clk_i),
    .nrst_i        (nrst_i),
    .bipolar_i     (bipolar),        // [RL6]
    .valid_i       (conv_done_i),
    .offset_code_i (conv_code_i),
    .valid_o       (result_valid_o),
    .result_o      (result_o)
  );

  // **********************************************************************
  // Checks
  // **********************************************************************
  // Four of the checks tie outputs back to the code that was written, so a
  // decode that is wrong fires here rather than agreeing with itself.
  a_ref_source: assert property ( // [RL1]
    @(posedge core_clk_i) disable iff (!nrst_i)
    setup_wr_i |=> (ref_src_o == arc_pkg::ARC_REF_INTERNAL) ==
      $past(setup_sel_i[`ARC_SEL_TOP]))
    else $error("Reference source does not follow the select top bit.");

  a_ref_external: assert property ( // [RL1]
    @(posedge core_clk_i) disable iff (!nrst_i)
    setup_wr_i |=> (ref_src_o == arc_pkg::ARC_REF_EXTERNAL) ==
      (!$past(setup_sel_i[`ARC_SEL_TOP]) && $past(setup_sel_i[`ARC_SEL_MID])))
    else $error("External reference does not follow the select bits.");

  a_pin_drive_out: assert property ( // [RL2]
    @(posedge core_clk_i) disable iff (!nrst_i)
    (pin_mode_o == arc_pkg::ARC_PIN_REF_OUT) |-> sel_top && sel_mid)
    else $error("Shared pin driven as output without both upper bits.");

  a_pin_mode_write: assert property ( // [RL2]
    @(posedge core_clk_i) disable iff (!nrst_i)
    setup_wr_i |=> (pin_mode_o == arc_pkg::ARC_PIN_ANALOG) ==
      !$past(setup_sel_i[`ARC_SEL_MID]))
    else $error("Shared pin function does not follow the middle bit.");

  a_hold_ref_on: assert property ( // [RL3]
    @(posedge core_clk_i) disable iff (!nrst_i)
    (int_ref_hold_o && !setup_wr_i) |=> int_ref_hold_o)
    else $error("Internal reference dropped without a setup rewrite.");

  a_hold_follows: assert property ( // [RL3]
    @(posedge core_clk_i) disable iff (!nrst_i)
    setup_wr_i |=> int_ref_hold_o ==
      ($past(setup_sel_i[`ARC_SEL_TOP]) && $past(setup_sel_i[`ARC_SEL_LOW])))
    else $error("Internal reference hold does not follow the written code.");

  a_pin_as_gnd: assert property ( // [RL4]
    @(posedge core_clk_i) disable iff (!nrst_i)
    shared_pin_as_gnd_o |-> pin_function_bit_o && conv_diff_i)
    else $error("Shared pin grounded while it is an analog input.");

  a_scan_cap_ref: assert property ( // [RL5]
    @(posedge core_clk_i) disable iff (!nrst_i)
    (sel_mid && single_ended) |-> scan_top_o <= top_ref)
    else $error("Scan reaches the shared reference pin.");

  a_scan_keeps_low: assert property ( // [RL5]
    @(posedge core_clk_i) disable iff (!nrst_i)
    (chan <= top_ref) |-> scan_top_o == chan)
    else $error("Scan top moved although the channel is below the cap.");

  a_reset_default: assert property ( // [RL7]
    @(posedge core_clk_i)
    !nrst_i |=> ref_src_o == arc_pkg::ARC_REF_SUPPLY && single_ended_o &&
      !bipolar_o && !ext_clk_o && chan_sel_o == `ARC_CH_RST &&
      pin_mode_o == arc_pkg::ARC_PIN_ANALOG && analog_pwr_o &&
      !result_valid_o)
    else $error("Power-on defaults are wrong.");

  a_auto_sd_idle: assert property ( // [RL8]
    @(posedge core_clk_i) disable iff (!nrst_i)
    (auto_sd && !conv_busy_i && !addr_match_i && !setup_wr_i)[*2]
      |-> !analog_pwr_o)
    else $error("Analog not shut down while idle in automatic shutdown.");

  a_auto_sd_wake: assert property ( // [RL8]
    @(posedge core_clk_i) disable iff (!nrst_i)
    addr_match_i |=> analog_pwr_o)
    else $error("Analog not powered up after a valid address.");
endmodule

// [tb/arc_host_model.sv]
// Host side model issuing setup, configuration and conversion events.
`timescale 1ns/1ns
module arc_host_model (
  input  wire logic   core_clk_i,
  output logic        setup_wr_o,
  output logic [2:0]  setup_sel_o,
  output logic        setup_ext_clk_o,
  output logic        setup_bipolar_o,
  output logic        cfg_wr_o,
  output logic        cfg_single_ended_o,
  output logic [3:0]  cfg_chan_o,
  output logic        addr_match_o,
  output logic        conv_busy_o,
  output logic        conv_done_o,
  output logic [11:0] conv_code_o,
  output logic [3:0]  conv_chan_o,
  output logic        conv_diff_o
);
  // ************************************************************
  // Stimulus changes only after a falling edge.
  // ************************************************************
  initial begin
    {setup_wr_o, cfg_wr_o, addr_match_o, conv_busy_o, conv_done_o} = 5'h0;
    {setup_sel_o, setup_ext_clk_o, setup_bipolar_o} = 5'h0;
    {cfg_single_ended_o, cfg_chan_o, conv_diff_o, conv_chan_o} = 10'h0;
    conv_code_o = 12'h0;
  end
  // Fields invert once the strobe drops, so stale data never looks valid.
  task automatic put_setup(input logic [2:0] s, input logic e, input logic b);
    @(negedge core_clk_i);
    {setup_sel_o, setup_ext_clk_o, setup_bipolar_o} = {s, e, b};
    setup_wr_o = 1'b1;
    @(negedge core_clk_i);
    {setup_sel_o, setup_ext_clk_o, setup_bipolar_o} = ~{s, e, b};
    setup_wr_o = 1'b0;
  endtask
  task automatic put_cfg(input logic se, input logic [3:0] ch);
    @(negedge core_clk_i);
    {cfg_single_ended_o, cfg_chan_o, cfg_wr_o} = {se, ch, 1'b1};
    @(negedge core_clk_i);
    {cfg_single_ended_o, cfg_chan_o, cfg_wr_o} = {~se, ~ch, 1'b0};
  endtask
  // Channel and mode stay up: they describe the conversion in progress.
  task automatic convert(input logic [11:0] c, input logic [3:0] ch,
                         input logic d);
    @(negedge core_clk_i);
    {conv_code_o, conv_chan_o, conv_diff_o, conv_done_o} = {c, ch, d, 1'b1};
    @(negedge core_clk_i);
    {conv_code_o, conv_done_o} = {~c, 1'b0};
  endtask
  task automatic pulse_addr;
    @(negedge core_clk_i);
    addr_match_o = 1'b1;
    @(negedge core_clk_i);
    addr_match_o = 1'b0;
  endtask
  task automatic set_busy(input logic b);
    @(negedge core_clk_i);
    conv_busy_o = b;
  endtask
endmodule

// [tb/arc_ref_ctrl_tb_top.sv]
// Self-checking bench for the reference select and coding control.
`timescale 1ns/1ns
`include "arc_defs.svh"
module arc_ref_ctrl_tb_top;
  logic                   core_clk_i = 1'b0;
  logic                   nrst_i     = 1'b0;
  logic                   s_wr, s_ext, s_bip, c_wr, c_se, a_m, busy, done;
  logic                   diff, pfb, hold, apwr, eclk, bip, se, gnd, rvld;
  logic [2:0]             sel, s;
  logic [3:0]             c_ch, v_ch, chs, top, ch, lim;
  logic [11:0]            code, res;
  arc_pkg::arc_ref_src_t  src;
  arc_pkg::arc_pin_mode_t pm;
  int                     miscompares     = 0;
  int                     samples_checked = 0;
  logic [11:0]            codes [4] = '{12'h000, 12'h7ff, 12'h800, 12'hfff};
  logic [3:0]             chans [3] = '{4'h5, 4'hb, 4'hf};
  always #20 core_clk_i = ~core_clk_i;
  arc_host_model host_u (.core_clk_i(core_clk_i), .setup_wr_o(s_wr),
    .setup_sel_o(sel), .setup_ext_clk_o(s_ext), .setup_bipolar_o(s_bip),
    .cfg_wr_o(c_wr), .cfg_single_ended_o(c_se), .cfg_chan_o(c_ch),
    .addr_match_o(a_m), .conv_busy_o(busy), .conv_done_o(done),
    .conv_code_o(code), .conv_chan_o(v_ch), .conv_diff_o(diff));
  arc_ref_ctrl #(.LARGE_VARIANT(1'b1)) dut_u (.core_clk_i(core_clk_i),
    .nrst_i(nrst_i), .setup_wr_i(s_wr), .setup_sel_i(sel),
    .setup_ext_clk_i(s_ext), .setup_bipolar_i(s_bip), .cfg_wr_i(c_wr),
    .cfg_single_ended_i(c_se), .cfg_chan_i(c_ch), .addr_match_i(a_m),
    .conv_busy_i(busy), .conv_done_i(done), .conv_code_i(code),
    .conv_chan_i(v_ch), .conv_diff_i(diff), .ref_src_o(src),
    .pin_mode_o(pm), .pin_function_bit_o(pfb), .int_ref_hold_o(hold),
    .analog_pwr_o(apwr), .ext_clk_o(eclk), .bipolar_o(bip),
    .single_ended_o(se), .chan_sel_o(chs), .scan_top_o(top),
    .shared_pin_as_gnd_o(gnd), .result_valid_o(rvld), .result_o(res));
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Single-ended, unipolar, channel zero, internal clock, supply reference.
  task automatic check_defaults;
    check({8'h0, src, pm}, 12'h0);
    check({7'h0, se, eclk, bip, apwr, rvld}, 12'h012);
    check({8'h0, chs}, 12'h0);
  endtask
  // ************************************************************
  // Main sequence; every wait is a fixed count of cycles.
  // ************************************************************
  initial begin
    repeat (2) @(negedge core_clk_i);
    nrst_i = 1'b1;
    check_defaults();
    for (int i = 0; i < 8; i++) begin
      s = 3'(i);
      host_u.put_setup(s, s[0], s[1]);
      check({10'h0, src}, s[2] ? 12'h2 : {11'h0, s[1]});
      check({10'h0, pm}, !s[1] ? 12'h0 : (s[2] ? 12'h2 : 12'h1));
      check({10'h0, pfb, hold}, {10'h0, s[1], s[2] & s[0]});
      check({10'h0, eclk, bip}, {10'h0, s[0], s[1]});
    end
    // Limiter cap drops by one for single-ended scans with a reference pin;
    // the last pass is not single-ended and keeps the full range.
    for (int i = 0; i < 6; i++) begin
      s = (i < 3) ? 3'h0 : 3'h2;
      ch = chans[i % 3];
      lim = (s[1] && i < 5) ? `ARC_CH_CAP_LARGE : `ARC_CH_MAX_LARGE;
      lim = (ch > lim) ? lim : ch;
      host_u.put_setup(s, 1'b0, 1'b0);
      host_u.put_cfg(i < 5, ch);
      check({7'h0, se, top}, {7'h0, (i < 5), lim});
    end
    // Coding at the code boundaries, and the grounded shared pin.
    for (int i = 0; i < 6; i++) begin
      s = i[0] ? 3'h6 : 3'h0;
      host_u.put_setup(s, 1'b0, i[1]);
      host_u.convert(codes[i % 4], `ARC_CH_MAX_LARGE, i != 5);
      check({10'h0, gnd, rvld}, {10'h0, s[1] & (i != 5), 1'b1});
      check(res, codes[i % 4] ^ {i[1], 11'h0});
      @(negedge core_clk_i);
      check({11'h0, rvld}, 12'h0);
    end
    // Power stays up while busy, drops when idle, wakes on an address.
    host_u.set_busy(1'b1);
    host_u.put_setup(`ARC_SEL_AUTO_SD, 1'b0, 1'b0);
    @(negedge core_clk_i);
    check({11'h0, apwr}, 12'h1);
    host_u.set_busy(1'b0);
    @(negedge core_clk_i);
    check({11'h0, apwr}, 12'h0);
    host_u.pulse_addr();
    check({11'h0, apwr}, 12'h1);
    @(negedge core_clk_i);
    check({11'h0, apwr}, 12'h0);
    host_u.put_cfg(1'b0, 4'h5);
    check({7'h0, se, chs}, 12'h005);
    nrst_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    nrst_i = 1'b1;
    check_defaults();
    report_and_stop();
  end
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end
endmodule
